// ### hdl/pebl_pkg.sv
// constants and types shared by the parallel eprom boot loader
package pebl_pkg;

  // address map
  localparam logic [15:0] RAM_FIRST = 16'h0100;
  localparam logic [15:0] CHAR_FIRST = 16'h0400;
  localparam logic [7:0] LOW_LAST = 8'hff;
  localparam logic [7:0] CHAR_END_HI = 8'h0b;
  localparam logic [7:0] PROG_FIRST_HI = 8'h20;
  localparam logic [7:0] PROG_END_HI = 8'h7f;
  localparam logic [15:0] VEC_FIRST = 16'h7ff0;
  localparam logic [7:0] VEC_END_HI = 8'h80;

  // mode switch codes on port c bits 3:2
  localparam logic [1:0] MODE_RUN_RAM = 2'h3;

  // sequencing counts
  localparam logic [1:0] PROG_PASSES = 2'h2;
  localparam logic [2:0] BOOT_CYC = 3'h4;
  localparam int unsigned RAM_WR_CYC = 1;

  // timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned PROG_PULSE_US = 2000;
  localparam int unsigned PROG_PULSE_CYC = PROG_PULSE_US * CLK_MHZ;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned BLINK_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;

  // on-chip memory request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
  } pebl_mem_req_t;

  typedef enum logic [12:0] {
    ST_BOOT = 13'h0001,
    ST_MODE = 13'h0002,
    ST_LAT_A = 13'h0004,
    ST_LAT_B = 13'h0008,
    ST_LAT_C = 13'h0010,
    ST_HS_RDY = 13'h0020,
    ST_HS_LOW = 13'h0040,
    ST_WRITE = 13'h0080,
    ST_CHECK = 13'h0100,
    ST_NEXT = 13'h0200,
    ST_PASS = 13'h0400,
    ST_FAIL = 13'h0800,
    ST_HALT = 13'h1000
  } pebl_state_t;

endpackage : pebl_pkg

// ### hdl/pebl_pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module pebl_pin_sync #(
  parameter int W = 11
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // pins and filtered result
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          o_sync[g] <= 1'b0;
        end else if (s2[g] == s3[g]) begin
          o_sync[g] <= s3[g];
        end
      end
    end
  endgenerate

endmodule : pebl_pin_sync

// ### hdl/pebl_addr_stepper.sv
// next-address logic: page carry, range gaps and end detection
`timescale 1ns/10ps
module pebl_addr_stepper
  import pebl_pkg::*;
(
  // current address and mode
  input wire logic [15:0] i_addr,
  input wire logic i_ram_mode,
  // next address and flags
  output logic [15:0] o_next,
  output logic o_page,
  output logic o_done
);

  logic [7:0] hi_inc;

  always_comb begin
    hi_inc = i_addr[15:8] + 8'h01;
    o_next = {i_addr[15:8], i_addr[7:0] + 8'h01};
    o_page = 1'b0;
    o_done = 1'b0;
    if (i_addr[7:0] == LOW_LAST) begin
      o_page = 1'b1;
      if (i_ram_mode || hi_inc == VEC_END_HI) begin
        o_done = 1'b1;
      end else if (hi_inc == PROG_END_HI) begin
        o_next = VEC_FIRST;
      end else if (hi_inc == CHAR_END_HI) begin
        o_next = {PROG_FIRST_HI, 8'h00};
      end else begin
        o_next = {hi_inc, 8'h00};
      end
    end
  end

endmodule : pebl_addr_stepper

// ### hdl/pebl_loader.sv
// Function
// - after reset start the loader and sample port c bits 2 and 3 for mode
// - both mode bits high: skip loading, jump to the ram program start
// - bit 2 high loads ram; bit 2 low programs+verifies (bit3 low) or verifies
// - before transfer set address bus and latched high byte to first char location, or to first ram location in ram load
// - port b is only an input data bus, never driven
// - ram load copies 256 bytes to same address, verifies, lights bit 7, stops
// - ram verify mismatch stalls forever presenting the failing address
// - ram load with bit 3 high ignores data, shows inverted ram on port d
// - bit 3 high at successful ram verify jumps to ram program instead of stop
// - eprom handling visits only the character, program and vector ranges
// - stepper carries low into high byte, skips gaps, ends after vectors
// - programming makes two passes with a 2 ms write pulse per byte
// - eprom verify lights bit 7 or stalls with failing address on port a and latch
// - before each port b read raise port c bit 1 and wait
// - bit 1 looped to bit 0 completes the handshake by itself
// - handshake ram load halts at first address, one step per bit 0 pulse
// - port d shows high address when programming, low seven bits in ram load
// - run led blinks while the loader is active
// - latch update: bit 5 high with high byte on port a, bit 5 low, restore low
`timescale 1ns/10ps
module pebl_loader
  import pebl_pkg::*;
#(
  parameter int unsigned PROG_PULSE_CYCLES = PROG_PULSE_CYC,
  parameter int unsigned BLINK_HALF_CYCLES = BLINK_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // external data bus and port c inputs
  input wire logic [7:0] i_port_b,
  input wire logic i_port_c_b0,
  input wire logic i_port_c_b2,
  input wire logic i_port_c_b3,
  // external address and port c outputs
  output logic [7:0] o_port_a,
  output logic o_port_c_b1,
  output logic o_port_c_b5,
  // indicators
  output logic [7:0] o_port_d,
  output logic o_run_led,
  // on-chip memory
  output pebl_mem_req_t o_mem,
  input wire logic [7:0] i_mem_rdata,
  // control transfer
  output logic o_jump_ram,
  output logic o_stop
);

  localparam int PULSE_I = int'(PROG_PULSE_CYCLES);

  pebl_state_t st;
  logic [10:0] pin_s;
  logic b0_s;
  logic b2_s;
  logic b3_s;
  logic [7:0] pb_s;
  logic [15:0] addr;
  logic ram_mode;
  logic verifying;
  logic [1:0] pass_cnt;
  logic [7:0] data;
  logic [23:0] wcnt;
  logic [23:0] wlen;
  logic [2:0] boot_cnt;
  logic [25:0] blink_cnt;
  logic pass_led;
  logic view;
  logic running;
  logic [15:0] step_next;
  logic step_page;
  logic step_done;
  logic [7:0] disp;

  // port b and port c bits 0, 2 and 3 enter through the synchroniser only
  pebl_pin_sync #(
    .W(11)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pin({i_port_c_b3, i_port_c_b2, i_port_c_b0, i_port_b}),
    .o_sync(pin_s)
  );

  assign pb_s = pin_s[7:0];
  assign b0_s = pin_s[8];
  assign b2_s = pin_s[9];
  assign b3_s = pin_s[10];

  pebl_addr_stepper u_step (
    .i_addr(addr),
    .i_ram_mode(ram_mode),
    .o_next(step_next),
    .o_page(step_page),
    .o_done(step_done)
  );

  assign view = ram_mode & b3_s;
  assign wlen = ram_mode ? 24'(RAM_WR_CYC) : 24'(PROG_PULSE_CYCLES);
  assign running = !(st inside {ST_PASS, ST_FAIL, ST_HALT});

  // settle the synchroniser before the mode sample
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      boot_cnt <= 3'h0;
    end else if (st == ST_BOOT) begin
      boot_cnt <= boot_cnt + 3'h1;
    end
  end

  // main sequencer
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st <= ST_BOOT;
    end else begin
      case (st)
        ST_BOOT: begin
          if (boot_cnt == BOOT_CYC - 3'h1) begin
            st <= ST_MODE;
          end
        end
        ST_MODE: begin
          if ({b3_s, b2_s} == MODE_RUN_RAM) begin
            st <= ST_HALT;
          end else begin
            st <= ST_LAT_A;
          end
        end
        ST_LAT_A: st <= ST_LAT_B;
        ST_LAT_B: st <= ST_LAT_C;
        ST_LAT_C: st <= ST_HS_RDY;
        ST_HS_RDY: begin
          if (b0_s) begin
            st <= ST_HS_LOW;
          end
        end
        ST_HS_LOW: begin
          if (!b0_s) begin
            if (view) begin
              st <= ST_NEXT;
            end else if (verifying) begin
              st <= ST_CHECK;
            end else begin
              st <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (wcnt == wlen - 24'h1) begin
            st <= ST_NEXT;
          end
        end
        ST_CHECK: begin
          if (i_mem_rdata != data) begin
            st <= ST_FAIL;
          end else begin
            st <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (step_done && verifying) begin
            st <= ST_PASS;
          end else if (step_done || step_page) begin
            st <= ST_LAT_A;
          end else begin
            st <= ST_HS_RDY;
          end
        end
        ST_PASS: begin
          if (ram_mode && !b3_s) begin
            st <= ST_HALT;
          end else begin
            st <= ST_HALT;
          end
        end
        ST_FAIL: st <= ST_FAIL;
        ST_HALT: st <= ST_HALT;
        default: st <= ST_BOOT;
      endcase
    end
  end

  // mode, pass and address state
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      addr <= CHAR_FIRST;
      ram_mode <= 1'b0;
      verifying <= 1'b0;
      pass_cnt <= 2'h0;
    end else if (st == ST_MODE) begin
      ram_mode <= b2_s;
      verifying <= !b2_s && b3_s;
      pass_cnt <= 2'h0;
      addr <= b2_s ? RAM_FIRST : CHAR_FIRST;
    end else if (st == ST_NEXT) begin
      if (step_done) begin
        addr <= ram_mode ? RAM_FIRST : CHAR_FIRST;
        if (!verifying) begin
          pass_cnt <= pass_cnt + 2'h1;
          verifying <= ram_mode || (pass_cnt == PROG_PASSES - 2'h1);
        end
      end else begin
        addr <= step_next;
      end
    end
  end

  // data capture on the strobe, held through its low phase
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      data <= 8'h00;
    end else if (st == ST_HS_RDY && b0_s) begin
      data <= pb_s;
    end
  end

  // write pulse timer
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wcnt <= 24'h0;
    end else if (st == ST_WRITE) begin
      wcnt <= wcnt + 24'h1;
    end else begin
      wcnt <= 24'h0;
    end
  end

  // on-chip memory port
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_mem <= '0;
    end else begin
      o_mem.addr <= addr;
      o_mem.wdata <= data;
      o_mem.we <= (st == ST_HS_LOW && !b0_s && !view && !verifying) ||
                  (st == ST_WRITE && wcnt != wlen - 24'h1);
    end
  end

  // external address bus and high-byte latch strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_port_a <= 8'h00;
      o_port_c_b5 <= 1'b0;
    end else begin
      o_port_c_b5 <= (st == ST_LAT_A);
      if (st == ST_LAT_A || st == ST_LAT_B) begin
        o_port_a <= addr[15:8];
      end else begin
        o_port_a <= addr[7:0];
      end
    end
  end

  // ready indication toward the data source
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_port_c_b1 <= 1'b0;
    end else begin
      o_port_c_b1 <= (st == ST_HS_RDY) && !b0_s;
    end
  end

  // progress and verify display
  always_comb begin
    if (view) begin
      disp = ~i_mem_rdata;
    end else if (ram_mode) begin
      disp = {1'b0, addr[6:0]};
    end else begin
      disp = {1'b0, addr[14:8]};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pass_led <= 1'b0;
    end else if (st == ST_PASS) begin
      pass_led <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_port_d <= 8'h00;
    end else begin
      o_port_d <= {pass_led || st == ST_PASS || (view && disp[7]), disp[6:0]};
    end
  end

  // run led blink
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      blink_cnt <= 26'h0;
      o_run_led <= 1'b0;
    end else if (!running) begin
      blink_cnt <= 26'h0;
      o_run_led <= 1'b0;
    end else if (blink_cnt == 26'(BLINK_HALF_CYCLES - 1)) begin
      blink_cnt <= 26'h0;
      o_run_led <= !o_run_led;
    end else begin
      blink_cnt <= blink_cnt + 26'h1;
    end
  end

  // control transfer outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_jump_ram <= 1'b0;
      o_stop <= 1'b0;
    end else begin
      o_jump_ram <= (st == ST_MODE && {b3_s, b2_s} == MODE_RUN_RAM) ||
                    (st == ST_PASS && ram_mode && b3_s) || o_jump_ram;
      o_stop <= (st == ST_PASS && !(ram_mode && b3_s)) || o_stop;
    end
  end

  // checks
  logic [23:0] we_len;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      we_len <= 24'h0;
    end else if (o_mem.we) begin
      we_len <= we_len + 24'h1;
    end else begin
      we_len <= 24'h0;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_boot_sample;
    $fell(i_rst) |-> ##4 (st == ST_MODE);
  endproperty
  a_boot_sample: assert property (p_boot_sample) else $error("mode not sampled after boot wait");

  property p_run_ram;
    (st == ST_MODE && b2_s && b3_s) |=> (st == ST_HALT) ##0 o_jump_ram ##1 !o_mem.we;
  endproperty
  a_run_ram: assert property (p_run_ram) else $error("run-ram mode did not jump");

  property p_mode_pick;
    (st == ST_MODE && !(b2_s && b3_s)) |=> (ram_mode == $past(b2_s)) &&
      (verifying == (!$past(b2_s) && $past(b3_s))) && (st == ST_LAT_A);
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("wrong mode chosen");

  property p_first_addr;
    (st == ST_MODE && !b2_s && !b3_s) |=> (addr == CHAR_FIRST) ##3 (o_port_a == addr[7:0]);
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("address bus not at first location");

  property p_latch_seq;
    $rose(o_port_c_b5) |-> (o_port_a == addr[15:8]) ##1 (!o_port_c_b5 && o_port_a == addr[15:8])
      ##1 (o_port_a == addr[7:0]);
  endproperty
  a_latch_seq: assert property (p_latch_seq) else $error("latch update order wrong");

  property p_fail_hold;
    (st == ST_FAIL) |=> (st == ST_FAIL) && $stable(addr) && !o_mem.we;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("failing address not held");

  property p_pulse_len;
    $fell(o_mem.we) && !ram_mode |-> ($past(we_len) == 24'(PULSE_I - 1));
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("write pulse length wrong");

  property p_gap_skip;
    (st == ST_NEXT && !ram_mode && addr == 16'h0aff) |=> (addr == 16'h2000) && (st == ST_LAT_A);
  endproperty
  a_gap_skip: assert property (p_gap_skip) else $error("gap after character area not skipped");

  property p_pass_led;
    (st == ST_PASS) |=> o_port_d[7] ##1 o_port_d[7];
  endproperty
  a_pass_led: assert property (p_pass_led) else $error("verify indication missing");

  property p_ready;
    (st == ST_HS_RDY && !b0_s) |=> o_port_c_b1;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not raised before read");

  property p_view_nowrite;
    (st == ST_HS_LOW && view) |=> !o_mem.we;
  endproperty
  a_view_nowrite: assert property (p_view_nowrite) else $error("write while showing ram");

  property p_ram_jump;
    (st == ST_PASS && ram_mode && b3_s) |=> o_jump_ram && !o_stop;
  endproperty
  a_ram_jump: assert property (p_ram_jump) else $error("no jump after ram verify");

  c_pass: cover property (st == ST_PASS);
  c_fail: cover property (st == ST_FAIL);
  c_vec: cover property (st == ST_NEXT && addr == 16'h7eff);
  c_view: cover property (st == ST_HS_LOW && view);

endmodule : pebl_loader

// ### verif/pebl_src_model.sv
// source-side model: external memory behind a high-byte latch, with stepped-source data timing
`timescale 1ns/10ps
module pebl_src_model
  import pebl_pkg::*;
(
  // address and strobes from the loader
  input wire logic [7:0] i_port_a,
  input wire logic i_port_c_b5,
  input wire logic i_port_c_b1,
  input wire logic i_port_c_b0,
  input wire logic i_manual,
  // data bus and latch contents
  output logic [7:0] o_port_b,
  output logic [7:0] o_hi
);
  logic [7:0] data;

  initial o_hi = 8'h00;

  // the latch takes the high byte as its strobe falls
  always @(negedge i_port_c_b5) begin
    o_hi = i_port_a;
  end

  assign data = i_port_a ^ o_hi ^ 8'h5a;

  // a stepped source holds valid data only from ready until its pulse ends, otherwise junk
  assign o_port_b = (!i_manual || i_port_c_b1 || i_port_c_b0) ? data : ~data;
endmodule : pebl_src_model

// ### verif/tb_pebl_loader.sv
// self-checking bench for the boot loader with on-chip memory and source models
`timescale 1ns/10ps
module tb_pebl_loader
  import pebl_pkg::*;
();
  typedef struct packed {
    logic m2;
    logic m3;
    logic [15:0] flt;
    logic ck_a;
    logic [7:0] a;
    logic [7:0] h;
    logic d7;
    logic st;
    logic jp;
  } pebl_row_t;

  logic i_clk_sys;
  logic i_rst;
  logic [7:0] port_b;
  logic b0;
  logic b2;
  logic b3;
  logic loop;
  logic btn;
  logic [7:0] port_a;
  logic [7:0] port_d;
  logic [7:0] hi;
  logic [7:0] rdata;
  logic b1;
  logic b5;
  logic led;
  logic jump;
  logic stop;
  pebl_mem_req_t mem_req;
  logic [7:0] mem [0:65535];
  logic [15:0] fault;
  pebl_row_t rows [4];
  int bad_count;
  int comparisons;

  always #2 i_clk_sys = ~i_clk_sys;

  pebl_loader #(.PROG_PULSE_CYCLES(8), .BLINK_HALF_CYCLES(16)) i_dut (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_port_b(port_b),
    .i_port_c_b0(b0),
    .i_port_c_b2(b2),
    .i_port_c_b3(b3),
    .o_port_a(port_a),
    .o_port_c_b1(b1),
    .o_port_c_b5(b5),
    .o_port_d(port_d),
    .o_run_led(led),
    .o_mem(mem_req),
    .i_mem_rdata(rdata),
    .o_jump_ram(jump),
    .o_stop(stop)
  );

  pebl_src_model i_src (
    .i_port_a(port_a),
    .i_port_c_b5(b5),
    .i_port_c_b1(b1),
    .i_port_c_b0(b0),
    .i_manual(~loop),
    .o_port_b(port_b),
    .o_hi(hi)
  );

  assign b0 = loop ? b1 : btn;

  // on-chip memory; a faulty cell drops its write
  always @(posedge i_clk_sys) begin
    if (mem_req.we === 1'h1 && mem_req.addr !== fault) begin
      mem[mem_req.addr] <= mem_req.wdata;
    end
  end
  assign rdata = mem[mem_req.addr];

  function automatic logic [7:0] src_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : src_byte

  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  // sel 0: ready, 1: memory write, 2: stop or jump
  task automatic wait_for(input int sel, input logic lvl, input int bound);
    logic v;
    for (int n = 0; n < bound; n++) begin
      @(negedge i_clk_sys);
      v = (sel == 0) ? b1 : (sel == 1) ? mem_req.we : (stop | jump);
      if (v === lvl) begin
        return;
      end
    end
    bad_count++;
    print_verdict();
  endtask : wait_for

  // mode pins settle well before reset is let go
  task automatic restart(input logic m2, input logic m3, input logic lp);
    @(negedge i_clk_sys);
    i_rst = 1'h1;
    b2 = m2;
    b3 = m3;
    loop = lp;
    btn = 1'h0;
    repeat (10) @(negedge i_clk_sys);
    i_rst = 1'h0;
  endtask : restart

  initial begin
    int n;
    int flips;
    logic led_seen;
    i_clk_sys = 1'h0;
    i_rst = 1'h1;
    b2 = 1'h0;
    b3 = 1'h0;
    loop = 1'h1;
    btn = 1'h0;
    fault = 16'hffff;
    bad_count = 0;
    comparisons = 0;
    rows[0] = '{1'h1, 1'h1, 16'hffff, 1'h0, 8'h00, 8'h00, 1'h0, 1'h0, 1'h1};
    rows[1] = '{1'h1, 1'h0, 16'hffff, 1'h0, 8'h00, 8'h00, 1'h1, 1'h1, 1'h0};
    rows[2] = '{1'h1, 1'h0, 16'h0155, 1'h1, 8'h55, 8'h01, 1'h0, 1'h0, 1'h0};
    rows[3] = '{1'h0, 1'h1, 16'h2000, 1'h1, 8'h00, 8'h20, 1'h0, 1'h0, 1'h0};
    foreach (rows[r]) begin
      fault = rows[r].flt;
      // eprom rows start from a good image except at the bad cell, so verify walks across the gap
      foreach (mem[k]) mem[k] = (rows[r].m2 || 16'(k) == rows[r].flt) ? 8'h00 : src_byte(16'(k));
      restart(rows[r].m2, rows[r].m3, 1'h1);
      if (rows[r].st || rows[r].jp) wait_for(2, 1'h1, 12000);
      else repeat (25000) @(negedge i_clk_sys);
      chk_bit(stop, rows[r].st);
      chk_bit(jump, rows[r].jp);
      chk_bit(port_d[7], rows[r].d7);
      if (rows[r].ck_a) chk_val({hi, port_a}, {rows[r].h, rows[r].a});
      if (rows[r].st) chk_val({8'h00, mem[16'h01ff]}, {8'h00, src_byte(16'h01ff)});
      if (rows[r].jp) chk_val({8'h00, mem[16'h0100]}, 16'h0000);
    end
    // programming: first byte, pulse length, next address
    fault = 16'hffff;
    restart(1'h0, 1'h0, 1'h1);
    wait_for(1, 1'h1, 300);
    chk_val(mem_req.addr, 16'h0400);
    chk_val({hi, mem_req.wdata}, {8'h04, src_byte(16'h0400)});
    chk_val({8'h00, port_d}, 16'h0004);
    n = 0;
    while (mem_req.we === 1'h1 && n < 100) begin
      n++;
      @(negedge i_clk_sys);
    end
    chk_val(n[15:0], 16'h0008);
    wait_for(1, 1'h1, 300);
    chk_val(mem_req.addr, 16'h0401);
    // single step without the loop-back link
    restart(1'h1, 1'h0, 1'h0);
    wait_for(0, 1'h1, 300);
    chk_val({hi, port_a}, 16'h0100);
    led_seen = led;
    flips = 0;
    repeat (40) begin
      @(negedge i_clk_sys);
      if (led !== led_seen) flips++;
      led_seen = led;
    end
    chk_bit(b1, 1'h1);
    chk_bit(flips > 0, 1'h1);
    btn = 1'h1;
    repeat (4) @(negedge i_clk_sys);
    btn = 1'h0;
    wait_for(0, 1'h0, 50);
    wait_for(0, 1'h1, 100);
    chk_val({hi, port_a}, 16'h0101);
    chk_val({8'h00, port_d}, 16'h0001);
    chk_val({8'h00, mem[16'h0100]}, {8'h00, src_byte(16'h0100)});
    // ram view, jump at the end, then reset once it has jumped
    restart(1'h1, 1'h0, 1'h1);
    for (int k = 256; k < 512; k++) mem[k] = 8'h33 ^ k[7:0];
    repeat (40) @(negedge i_clk_sys);
    b3 = 1'h1;
    repeat (20) @(negedge i_clk_sys);
    wait_for(0, 1'h1, 100);
    repeat (2) @(negedge i_clk_sys);
    chk_val({8'h00, port_d}, {8'h00, ~mem[{8'h01, port_a}]});
    wait_for(2, 1'h1, 12000);
    chk_bit(jump, 1'h1);
    chk_bit(stop, 1'h0);
    i_rst = 1'h1;
    repeat (2) @(negedge i_clk_sys);
    chk_bit(jump, 1'h0);
    chk_bit(mem_req.we, 1'h0);
    print_verdict();
  end
endmodule : tb_pebl_loader
